/* File: verilog/rsc_pkg.sv */
/*
  Constants, register map and carrier types of the reset state controller.
  Assumes a single 50 MHz master clock; slow clock arrives as a plain input.
  // Functional notes
  // - Priority highest first: power-up, brownout, watchdog, software, user pin reset.
  // - No watchdog reset entered while a user reset is active.
  // - No software reset starts while a user reset is active.
  // - In software reset a watchdog fault pre-empts; a low pin is ignored.
  // - In watchdog reset no software command and no user reset is accepted.
  // - Status bit 17 is busy during a software reset, clears when it ends.
  // - Status bit 16 shows the pin level, resampled every master clock edge.
  // - Status bit 0 sets on a pin falling edge, stays until status is read.
  // - Interrupt when pin edge flag, user irq enable set and user reset disabled.
  // - Brownout with brownout reset disabled sets bit 1; irq if enable bit 16.
  // - Status read clears pin edge and brownout flags and their interrupt.
  // - Keyed command write: bit 0 cpu, bit 2 peripherals, bit 3 pin reset.
  // - Command and mode writes need key 0xa5 in bits 31:24, else ignored.
  // - Cause field 10:8: power-up 000, watchdog 010, software 011, user 100, brownout 101.
  // - Reading status leaves the cause field unchanged.
  // - Mode bit 0 decides whether a low pin triggers a user reset.
  // - Pin pulse lasts 2^(length+1) slow cycles, length in mode bits 11:8.
  // - Software reset lasts 3 slow cycles; asserts at once, releases on slow clock.
  // - Command writes are ignored while the busy bit is set.
  // - Cause updates on cpu reset release; software only if cpu bit was set.
  // - A pin falling edge from our own drive starts no user reset.
*/
package rsc_pkg;

  localparam logic [7:0] OFS_COMMAND = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;

  localparam logic [7:0] WRITE_KEY = 8'ha5;
  localparam int KEY_LSB = 24;

  localparam int CMD_CPU_BIT = 0;
  localparam int CMD_PERIPH_BIT = 2;
  localparam int CMD_PIN_BIT = 3;

  localparam int ST_PIN_EDGE_BIT = 0;
  localparam int ST_BROWNOUT_BIT = 1;
  localparam int ST_CAUSE_LSB = 8;
  localparam int ST_PIN_LEVEL_BIT = 16;
  localparam int ST_BUSY_BIT = 17;

  localparam int MD_USER_EN_BIT = 0;
  localparam int MD_USER_IRQ_BIT = 4;
  localparam int MD_LEN_LSB = 8;
  localparam int MD_BROWNOUT_IRQ_BIT = 16;

  localparam logic [2:0] CAUSE_POWERUP = 3'h0;
  localparam logic [2:0] CAUSE_WATCHDOG = 3'h2;
  localparam logic [2:0] CAUSE_SOFTWARE = 3'h3;
  localparam logic [2:0] CAUSE_USER = 3'h4;
  localparam logic [2:0] CAUSE_BROWNOUT = 3'h5;

  localparam logic [3:0] SHORT_TICKS = 4'h3;
  localparam int STARTUP_TICKS_DEFAULT = 3;
  localparam int PULSE_CNT_W = 17;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

  typedef struct packed {
    logic brownout_irq_enable;
    logic [3:0] ext_pulse_length;
    logic user_reset_irq_enable;
    logic user_reset_enable;
  } rsc_mode_t;

  localparam rsc_mode_t MODE_RESET = '0;

  typedef struct packed {
    logic cpu;
    logic periph;
    logic pin;
  } rsc_cmd_t;

  typedef struct packed {
    logic cpu;
    logic periph;
  } rsc_lines_t;

  typedef enum logic [2:0] {
    RSC_POWERUP, RSC_RUN, RSC_BROWNOUT, RSC_WATCHDOG, RSC_SOFTWARE, RSC_USER
  } rsc_state_t;

endpackage

/* File: verilog/rsc_sync.sv */
/*
  Two flip-flop level synchronizer, one bit per lane.
  Assumes inputs are quasi-static levels; pulses shorter than one clock may be lost.
*/
`timescale 1ns/10ps
module rsc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

/* File: verilog/rsc_top.sv */
/*
  Reset state controller: source arbitration, reset lines, pin pulse shaping,
  cause reporting and status flags behind a simple strobe register port.
  Assumes slow_clock is far slower than clk, the pin is open drain with a pull-up,
  and watchdog_fault comes from logic on clk.
*/
`timescale 1ns/10ps
module rsc_top import rsc_pkg::*; #(
  parameter int STARTUP_TICKS = STARTUP_TICKS_DEFAULT
) (
  // Clock and power-up reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Reset sources
  input wire logic slow_clock,
  input wire logic brownout_in,
  input wire logic brownout_reset_enable,
  input wire logic watchdog_fault,
  // External reset pin, open drain
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  // Reset lines and interrupt
  output logic cpu_reset,
  output logic periph_reset,
  output logic irq
);

  // Synchronised inputs
  logic [3:0] sync_q;
  logic slow_s;
  logic brown_s;
  logic bod_en_s;
  logic pin_s;

  rsc_sync #(.WIDTH(4)) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in({slow_clock, brownout_in, brownout_reset_enable, ~pin_in}),
    .sync_out(sync_q)
  );

  assign slow_s = sync_q[3];
  assign brown_s = sync_q[2];
  assign bod_en_s = sync_q[1];
  // Pin lane runs inverted so its cleared reset value means idle high, no false edge
  assign pin_s = ~sync_q[0];

  // State and registers
  rsc_state_t state;
  rsc_state_t next_state;
  rsc_mode_t mode;
  rsc_cmd_t sw_cmd;
  rsc_lines_t next_lines;
  logic [3:0] tick_cnt;
  logic [PULSE_CNT_W-1:0] pulse_cnt;
  logic slow_d;
  logic slow_tick;
  logic pin_level;
  logic brown_d;
  logic pin_edge_flag;
  logic brownout_flag;
  logic [2:0] reset_cause;
  logic self_mask;
  logic hold;
  logic done;
  logic key_ok;
  logic cmd_write;
  logic cmd_any;
  logic sw_go;
  logic user_go;
  logic bod_hit;
  logic pulse_start;
  logic status_read;
  logic sw_cmd_busy;

  // Which lines a state asserts; software depends on the captured command
  function automatic rsc_lines_t lines_of(input rsc_state_t st, input rsc_cmd_t cmd);
    rsc_lines_t l;
    l = '0;
    case (st)
      RSC_POWERUP, RSC_BROWNOUT, RSC_WATCHDOG, RSC_USER: begin
        l.cpu = 1'b1;
        l.periph = 1'b1;
      end
      RSC_SOFTWARE: begin
        l.cpu = cmd.cpu;
        l.periph = cmd.periph;
      end
      default: l = '0;
    endcase
    return l;
  endfunction

  assign slow_tick = slow_s & ~slow_d;
  assign key_ok = (wdata[31:KEY_LSB] == WRITE_KEY);
  assign sw_cmd_busy = (state == RSC_SOFTWARE);
  assign cmd_any = wdata[CMD_CPU_BIT] | wdata[CMD_PERIPH_BIT] | wdata[CMD_PIN_BIT];
  assign cmd_write = wr & (addr == OFS_COMMAND) & key_ok & ~sw_cmd_busy;
  assign sw_go = cmd_write & cmd_any;
  // Own pin drive and its trailing low are masked from the user reset
  assign user_go = ~pin_level & mode.user_reset_enable & ~self_mask;
  assign bod_hit = brown_s & bod_en_s;
  assign status_read = rd & (addr == OFS_STATUS);

  // Brownout and user states wait for their source to go away first
  always_comb begin
    hold = 1'b0;
    if (state == RSC_BROWNOUT) begin
      hold = brown_s;
    end else if (state == RSC_USER) begin
      hold = ~pin_level;
    end
  end

  always_comb begin
    done = 1'b0;
    if (state == RSC_POWERUP) begin
      done = slow_tick & (32'(tick_cnt) == STARTUP_TICKS - 1);
    end else begin
      done = slow_tick & ~hold & (tick_cnt == SHORT_TICKS - 4'h1);
    end
  end

  always_comb begin
    next_state = state;
    if (bod_hit && state != RSC_POWERUP && state != RSC_BROWNOUT) begin
      next_state = RSC_BROWNOUT;
    end else begin
      case (state)
        RSC_POWERUP: begin
          if (done) begin
            next_state = RSC_RUN;
          end
        end
        RSC_RUN: begin
          if (watchdog_fault) begin
            next_state = RSC_WATCHDOG;
          end else if (sw_go) begin
            next_state = RSC_SOFTWARE;
          end else if (user_go) begin
            next_state = RSC_USER;
          end
        end
        RSC_SOFTWARE: begin
          // Pin level is not looked at here
          if (watchdog_fault) begin
            next_state = RSC_WATCHDOG;
          end else if (done) begin
            next_state = RSC_RUN;
          end
        end
        RSC_WATCHDOG: begin
          // No command or user entry accepted while here
          if (done) begin
            next_state = RSC_RUN;
          end
        end
        RSC_USER: begin
          // Watchdog and commands cannot reach this state
          if (done) begin
            next_state = RSC_RUN;
          end
        end
        RSC_BROWNOUT: begin
          if (done) begin
            next_state = RSC_RUN;
          end
        end
        default: next_state = RSC_POWERUP;
      endcase
    end
  end

  assign pulse_start = (next_state != state) &&
    (next_state == RSC_BROWNOUT || next_state == RSC_WATCHDOG ||
     (next_state == RSC_SOFTWARE && wdata[CMD_PIN_BIT]));

  always_comb begin
    next_lines = lines_of(next_state, sw_cmd);
    if (next_state == RSC_SOFTWARE && state != RSC_SOFTWARE) begin
      next_lines = lines_of(next_state, rsc_cmd_t'{cpu: wdata[CMD_CPU_BIT], periph: wdata[CMD_PERIPH_BIT], pin: 1'b0});
    end
  end

  // Slow clock edge detection
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      slow_d <= 1'b0;
    end else begin
      slow_d <= slow_s;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= RSC_POWERUP;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_cnt <= '0;
    end else if (next_state != state || hold) begin
      tick_cnt <= '0;
    end else if (slow_tick) begin
      tick_cnt <= tick_cnt + 4'h1;
    end
  end

  // Command captured on entry into software reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sw_cmd <= '0;
    end else if (next_state == RSC_SOFTWARE && state != RSC_SOFTWARE) begin
      sw_cmd <= '{cpu: wdata[CMD_CPU_BIT], periph: wdata[CMD_PERIPH_BIT], pin: wdata[CMD_PIN_BIT]};
    end
  end

  // Lines assert in the write cycle's next edge, release only on a slow tick
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cpu_reset <= 1'b1;
      periph_reset <= 1'b1;
    end else begin
      cpu_reset <= next_lines.cpu;
      periph_reset <= next_lines.periph;
    end
  end

  // Cause recorded when the cpu reset drops
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reset_cause <= CAUSE_POWERUP;
    end else if (cpu_reset && !next_lines.cpu) begin
      case (state)
        RSC_POWERUP: reset_cause <= CAUSE_POWERUP;
        RSC_BROWNOUT: reset_cause <= CAUSE_BROWNOUT;
        RSC_WATCHDOG: reset_cause <= CAUSE_WATCHDOG;
        RSC_SOFTWARE: reset_cause <= CAUSE_SOFTWARE;
        RSC_USER: reset_cause <= CAUSE_USER;
        default: reset_cause <= reset_cause;
      endcase
    end
  end

  // Pin pulse counts slow ticks, so its start may be short by one tick
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pulse_cnt <= '0;
    end else if (pulse_start) begin
      pulse_cnt <= PULSE_CNT_W'(1) << ({1'b0, mode.ext_pulse_length} + 5'h1);
    end else if (slow_tick && pulse_cnt != '0) begin
      pulse_cnt <= pulse_cnt - PULSE_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_out <= 1'b0;
      pin_oe <= pulse_start | (pulse_cnt > PULSE_CNT_W'(1)) | (pulse_cnt == PULSE_CNT_W'(1) && !slow_tick);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      self_mask <= 1'b0;
    end else if (pulse_start) begin
      self_mask <= 1'b1;
    end else if (!pin_oe && pulse_cnt == '0 && pin_level) begin
      self_mask <= 1'b0;
    end
  end

  // Pin level and brownout edge history
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_level <= 1'b1;
      brown_d <= 1'b0;
    end else begin
      pin_level <= pin_s;
      brown_d <= brown_s;
    end
  end

  // Set wins over the clear of a status read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_edge_flag <= 1'b0;
    end else if (pin_level && !pin_s) begin
      pin_edge_flag <= 1'b1;
    end else if (status_read) begin
      pin_edge_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      brownout_flag <= 1'b0;
    end else if (brown_s && !brown_d && !bod_en_s) begin
      brownout_flag <= 1'b1;
    end else if (status_read) begin
      brownout_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= (pin_edge_flag & mode.user_reset_irq_enable & ~mode.user_reset_enable) |
             (brownout_flag & mode.brownout_irq_enable);
    end
  end

  // Mode register, keyed write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode <= MODE_RESET;
    end else if (wr && addr == OFS_MODE && key_ok) begin
      mode.user_reset_enable <= wdata[MD_USER_EN_BIT];
      mode.user_reset_irq_enable <= wdata[MD_USER_IRQ_BIT];
      mode.ext_pulse_length <= wdata[MD_LEN_LSB +: 4];
      mode.brownout_irq_enable <= wdata[MD_BROWNOUT_IRQ_BIT];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= STATUS_RESET;
    end else begin
      rdata <= '0;
      if (rd && addr == OFS_STATUS) begin
        rdata[ST_PIN_EDGE_BIT] <= pin_edge_flag;
        rdata[ST_BROWNOUT_BIT] <= brownout_flag;
        rdata[ST_CAUSE_LSB +: 3] <= reset_cause;
        rdata[ST_PIN_LEVEL_BIT] <= pin_level;
        rdata[ST_BUSY_BIT] <= sw_cmd_busy;
      end else if (rd && addr == OFS_MODE) begin
        rdata[MD_USER_EN_BIT] <= mode.user_reset_enable;
        rdata[MD_USER_IRQ_BIT] <= mode.user_reset_irq_enable;
        rdata[MD_LEN_LSB +: 4] <= mode.ext_pulse_length;
        rdata[MD_BROWNOUT_IRQ_BIT] <= mode.brownout_irq_enable;
      end
    end
  end

endmodule

/* File: bench/rsc_checker.sv */
/*
  Port checker of the reset controller, bound to rsc_top.
  Assumes a slow clock of at least 8 clk a period and a bench that waits out busy.
*/
`timescale 1ns/10ps
module rsc_checker import rsc_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // Pin, lines, interrupt
  input wire logic pin_in,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic cpu_reset,
  input wire logic periph_reset,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic idle;
  logic key_cmd;
  logic st_rd;
  // Only judged from idle, so a pending reset cannot mask a command
  assign idle = !cpu_reset && !periph_reset && !pin_oe;
  assign key_cmd = wr && addr == OFS_COMMAND && wdata[31:24] == WRITE_KEY && idle;
  assign st_rd = rd && addr == OFS_STATUS;
  a_cmd_lines: assert property (key_cmd |=> cpu_reset == $past(wdata[0]) && periph_reset == $past(wdata[2]))
    else $error("command lines wrong");
  a_cmd_pin: assert property (key_cmd && wdata[3] |-> ##[1:4] pin_oe)
    else $error("pin drive missing");
  a_sw_hold: assert property (key_cmd && wdata[0] |=> cpu_reset [*8] ##[1:200] !cpu_reset)
    else $error("software reset length wrong");
  a_bad_key: assert property (wr && addr == OFS_COMMAND && wdata[31:24] != WRITE_KEY && idle |=> idle)
    else $error("unkeyed command acted");
  a_open_drain: assert property (pin_oe |-> !pin_out)
    else $error("pin driven high");
  a_pulse_min: assert property ($rose(pin_oe) |-> pin_oe [*8])
    else $error("pin pulse too short");
  a_cmd_reads_zero: assert property (rd && addr == OFS_COMMAND |=> rdata == 32'h0)
    else $error("command read not zero");
  a_status_reserved: assert property (st_rd |=> (rdata & 32'hfffcf8fc) == 32'h0)
    else $error("status reserved bits set");
  a_pin_level: assert property (st_rd && $past(pin_in) == pin_in && $past(pin_in, 2) == pin_in
    && $past(pin_in, 3) == pin_in |=> rdata[16] == $past(pin_in))
    else $error("pin level wrong");
  a_read_clears_irq: assert property (st_rd |-> ##2 !irq)
    else $error("irq after status read");
  c_sw_cmd: cover property (key_cmd && wdata[0]);
  c_irq: cover property ($rose(irq));
  c_pulse: cover property ($fell(pin_oe));
endmodule
bind rsc_top rsc_checker rsc_checker_i (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .cpu_reset(cpu_reset),
  .periph_reset(periph_reset), .irq(irq));

/* File: bench/rsc_far_side.sv */
/*
  Far side: free slow oscillator and the pulled-up reset wire with an outside device.
  Assumes the bench asks for outside pull-downs through ext_low.
*/
`timescale 1ns/10ps
module rsc_far_side #(
  parameter int SLOW_HALF_NS = 160
) (
  // From the controller
  input wire logic pin_out,
  input wire logic pin_oe,
  // Outside device
  input wire logic ext_low,
  // To the controller
  output logic slow_clock,
  output logic pin_in
);
  // Oscillator runs free, phase unrelated to clk
  initial begin
    slow_clock = 1'b0;
    #7;
    forever #(SLOW_HALF_NS) slow_clock = ~slow_clock;
  end
  // Pull-up wins when nobody pulls low
  assign pin_in = !(pin_oe && !pin_out) && !ext_low;
endmodule

/* File: bench/rsc_top_bench.sv */
/*
  Bench of the reset controller: registers, flags, commands, reset sources, causes.
  Assumes the far side model for slow clock and pin; seed starts at 96.
*/
`timescale 1ns/10ps
`define CHK(a, b) check_val(32'(a), 32'(b));
module rsc_top_bench import rsc_pkg::*;;
  logic clk, reset, wr, rd, brownout_in, brownout_reset_enable, watchdog_fault, ext_low;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, got, d;
  logic [2:0] cause;
  logic slow_clock, pin_in, pin_out, pin_oe, cpu_reset, periph_reset, irq;
  logic [3:0] cmd_tab [5] = '{4'h1, 4'h4, 4'h8, 4'h5, 4'hd};
  integer seed;
  int n_fail, check_count, i, k;
  rsc_top #(.STARTUP_TICKS(1)) rsc_top_i (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .slow_clock(slow_clock), .brownout_in(brownout_in),
    .brownout_reset_enable(brownout_reset_enable), .watchdog_fault(watchdog_fault), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .cpu_reset(cpu_reset), .periph_reset(periph_reset), .irq(irq));
  rsc_far_side rsc_far_side_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_low(ext_low),
    .slow_clock(slow_clock), .pin_in(pin_in));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] st_exp(input logic [2:0] c, input logic lvl, input logic [1:0] fl);
    return {15'h0, lvl, 5'h0, c, 6'h0, fl};
  endfunction
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    got = rdata;
  endtask
  // Waits until both lines and the pin drive are low, then pads for the synchronizers
  task automatic wait_idle;
    k = 0;
    while ((cpu_reset | periph_reset | pin_oe) !== 1'b0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000) n_fail++;
    cyc(64);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    tally_and_finish;
  end
  initial begin
    seed = 96;
    n_fail = 0;
    check_count = 0;
    {reset, wr, rd, brownout_in, brownout_reset_enable, watchdog_fault, ext_low} = 7'h40;
    addr = 8'h00;
    wdata = 32'h0;
    cyc(20);
    reset <= 1'b0;
    wait_idle;
    rd_reg(OFS_STATUS); `CHK(got, st_exp(CAUSE_POWERUP, 1'b1, 2'h0))
    rd_reg(OFS_MODE); `CHK(got, 32'h0)
    rd_reg(8'h0c); `CHK(got, 32'h0)
    rd_reg(OFS_COMMAND); `CHK(got, 32'h0)
    wr_reg(OFS_COMMAND, 32'h5a00000d); cyc(4); #1;
    `CHK({cpu_reset, periph_reset, pin_oe}, 3'h0)
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      wr_reg(OFS_MODE, {WRITE_KEY, d[23:0]});
      wr_reg(OFS_MODE, {~WRITE_KEY, ~d[23:0]});
      rd_reg(OFS_MODE); `CHK(got, d & 32'h00010f11)
    end
    $display("registers done");
    wr_reg(OFS_MODE, {WRITE_KEY, 24'h000110});
    ext_low <= 1'b1; cyc(10); #1;
    `CHK({irq, cpu_reset}, 2'h2)
    rd_reg(OFS_STATUS); `CHK(got, st_exp(CAUSE_POWERUP, 1'b0, 2'h1))
    cyc(2); #1; `CHK(irq, 1'b0)
    @(posedge clk); ext_low <= 1'b0; cyc(10);
    rd_reg(OFS_STATUS); `CHK(got, st_exp(CAUSE_POWERUP, 1'b1, 2'h0))
    wr_reg(OFS_MODE, {WRITE_KEY, 24'h010100});
    brownout_in <= 1'b1; cyc(8); brownout_in <= 1'b0; cyc(8); #1;
    `CHK({irq, cpu_reset}, 2'h2)
    rd_reg(OFS_STATUS); `CHK(got[1:0], 2'h2)
    cyc(2); #1; `CHK(irq, 1'b0)
    $display("flags done");
    wr_reg(OFS_MODE, {WRITE_KEY, 24'h000101});
    cause = CAUSE_POWERUP;
    for (i = 0; i < 5; i++) begin
      d = {28'h0, cmd_tab[i]};
      wr_reg(OFS_COMMAND, {WRITE_KEY, d[23:0]}); #1;
      `CHK({cpu_reset, periph_reset}, {d[0], d[2]})
      rd_reg(OFS_STATUS); `CHK(got[17], 1'b1)
      wr_reg(OFS_COMMAND, {WRITE_KEY, 20'h0, ~d[3:0] & 4'hd}); #1;
      `CHK({cpu_reset, periph_reset}, {d[0], d[2]})
      wait_idle;
      if (d[0]) cause = CAUSE_SOFTWARE;
      rd_reg(OFS_STATUS); `CHK({got[17], got[10:8]}, {1'b0, cause})
    end
    for (i = 0; i < 3; i++) begin
      wr_reg(OFS_MODE, {WRITE_KEY, 12'h0, i[3:0], 8'h00});
      wr_reg(OFS_COMMAND, {WRITE_KEY, 24'h000008});
      #1;
      k = 0;
      while (pin_oe === 1'b1 && k < 5000) begin
        @(posedge clk); #1;
        k++;
      end
      `CHK(k >= ((2 << i) - 1) * 16 - 2 && k <= (2 << i) * 16 + 2, 1'b1)
      wait_idle;
    end
    $display("software resets done");
    wr_reg(OFS_MODE, {WRITE_KEY, 24'h000001});
    wr_reg(OFS_COMMAND, {WRITE_KEY, 24'h000004});
    ext_low <= 1'b1; cyc(6); #1; `CHK(cpu_reset, 1'b0)
    @(posedge clk); ext_low <= 1'b0; watchdog_fault <= 1'b1;
    @(posedge clk); watchdog_fault <= 1'b0;
    wr_reg(OFS_COMMAND, {WRITE_KEY, 24'h000001});
    wait_idle;
    rd_reg(OFS_STATUS); `CHK(got[10:8], CAUSE_WATCHDOG)
    @(posedge clk); ext_low <= 1'b1; cyc(8); #1; `CHK({cpu_reset, periph_reset}, 2'h3)
    @(posedge clk); watchdog_fault <= 1'b1; @(posedge clk); watchdog_fault <= 1'b0;
    wr_reg(OFS_COMMAND, {WRITE_KEY, 24'h000001});
    @(posedge clk); ext_low <= 1'b0;
    wait_idle;
    rd_reg(OFS_STATUS); `CHK(got[10:8], CAUSE_USER)
    @(posedge clk); brownout_reset_enable <= 1'b1; cyc(4); brownout_in <= 1'b1; cyc(8); #1;
    `CHK(cpu_reset, 1'b1)
    @(posedge clk); watchdog_fault <= 1'b1; @(posedge clk); watchdog_fault <= 1'b0; brownout_in <= 1'b0;
    wait_idle;
    rd_reg(OFS_STATUS); `CHK(got[10:8], CAUSE_BROWNOUT)
    $display("reset sources done");
    tally_and_finish;
  end
endmodule
